// ===== logic/sfc_forward_executor.sv
// host spi forward-write executor with chain serial output
// assumes sclk/cs_n/sdi asynchronous; cfg and status from ref_clk logic
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.svh"
module sfc_forward_executor (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             spi_sclk,
  input  wire logic             spi_cs_n,
  input  wire logic             spi_sdi,
  output logic                  spi_sdo,
  output logic                  spi_sdo_oe,
  input  wire sfc_pkg::sfc_cfg_t cfg,
  input  wire logic [15:0]      status_word,
  input  wire logic             crc_flag_clr,
  output logic                  flag_spi_crc,
  output logic                  fault_out,
  output logic                  fault_oe,
  output logic                  soft_reset_req,
  output logic                  chain_clk,
  output logic                  chain_serial_out,
  output logic                  chain_busy
);
  import sfc_pkg::*;

  localparam logic [3:0] DIV_LAST = 4'(`SFC_CHAIN_DIV - 1);
  localparam logic [3:0] DIV_HALF = 4'(`SFC_CHAIN_DIV / 2);

  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `SFC_CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = crc_bit(r, w[i]);
    end
    crc_word = r;
  endfunction

  function automatic logic is_fwd(input logic [3:0] op);
    is_fwd = (op == `SFC_OP_FWD_CHK) || (op == `SFC_OP_FWD) ||
             (op == `SFC_OP_EXT_CHK) || (op == `SFC_OP_EXT);
  endfunction

  function automatic logic is_chk(input logic [3:0] op);
    is_chk = (op == `SFC_OP_FWD_CHK) || (op == `SFC_OP_EXT_CHK) ||
             (op == `SFC_OP_SRST);
  endfunction

  // pin synchronisers: sclk, cs_n, sdi
  logic [2:0] pin_raw;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic       sclk_d_ff;
  assign pin_raw = {spi_sclk, spi_cs_n, spi_sdi};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          // sclk rests at its idle low so no false edge follows reset
          sync1_ff[g] <= 1'(g != 2);
          sync2_ff[g] <= 1'(g != 2);
        end else begin
          sync1_ff[g] <= pin_raw[g];
          sync2_ff[g] <= sync1_ff[g];
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sync2_ff[2];
    end
  end

  logic        sclk_s;
  logic        cs_s;
  logic        sdi_s;
  logic        rise;
  logic        fall;
  assign sclk_s = sync2_ff[2];
  assign cs_s   = sync2_ff[1];
  assign sdi_s  = sync2_ff[0];
  assign rise   = sclk_s & ~sclk_d_ff & ~cs_s;
  assign fall   = ~sclk_s & sclk_d_ff & ~cs_s;

  // receive side state
  sfc_rx_state_t         rx_state_ff, nxt_rx_state;
  logic [3:0]            bit_cnt_ff, nxt_bit_cnt;
  logic [15:0]           rx_sh_ff, nxt_rx_sh;
  logic [15:0]           crc_ff, nxt_crc;
  logic                  xmodem_ff, nxt_xmodem;
  logic [3:0]            op_ff, nxt_op;
  sfc_job_t              job_ff, nxt_job;
  logic [`SFC_CNT_W-1:0] rx_words_ff, nxt_rx_words;
  logic [`SFC_Q_AW:0]    wr_ptr_ff, nxt_wr_ptr;
  logic [`SFC_Q_AW:0]    base_ptr_ff, nxt_base_ptr;
  logic                  go_ff, nxt_go;
  logic                  fired_ff, nxt_fired;
  logic [31:0]           ack_sh_ff, nxt_ack_sh;
  logic                  ack_half_ff, nxt_ack_half;
  logic                  sdo_ff, nxt_sdo;
  logic                  flag_ff, nxt_flag;
  logic                  fault_oe_ff, nxt_fault_oe;
  logic                  srst_ff, nxt_srst;

  // chain side state
  sfc_ch_state_t         ch_state_ff, nxt_ch_state;
  logic [3:0]            div_ff, nxt_div;
  logic                  clk_ff, nxt_clk;
  logic [15:0]           ch_sh_ff, nxt_ch_sh;
  logic [3:0]            ch_bit_ff, nxt_ch_bit;
  logic [`SFC_CNT_W-1:0] sent_ff, nxt_sent;
  logic [7:0]            ends_ff, nxt_ends;
  logic [`SFC_Q_AW:0]    rd_ptr_ff, nxt_rd_ptr;
  logic                  out_ff, nxt_out;

  logic [15:0]           rx_word;
  logic                  word_done;
  logic [`SFC_Q_AW:0]    q_count;
  logic                  q_full;
  logic                  push;
  logic                  crc_hit;
  logic                  crc_miss;
  logic                  lvl_hit;
  logic                  tick;
  logic                  chain_take;
  logic                  rd_en;
  logic [15:0]           q_rdata;

  assign rx_word   = {rx_sh_ff[14:0], sdi_s};
  assign word_done = rise && (bit_cnt_ff == 4'hF);
  assign q_count   = wr_ptr_ff - rd_ptr_ff;
  assign q_full    = q_count[`SFC_Q_AW];
  // words past a full queue are dropped; host keeps length in bounds
  assign push      = word_done && (rx_state_ff == RX_DATA) && !q_full;
  assign crc_hit   = word_done && (rx_state_ff == RX_CRC) && (rx_word == crc_ff);
  assign crc_miss  = word_done && (rx_state_ff == RX_CRC) && (rx_word != crc_ff);
  assign lvl_hit   = (q_count + 11'h001) >= cfg.tx_queue_start_level;
  assign tick      = (div_ff == DIV_LAST);
  assign chain_take = (ch_state_ff == CH_IDLE) && tick && go_ff;
  assign rd_en     = (ch_state_ff == CH_FETCH) && (q_count != 11'h000);

  sfc_queue_mem u_queue (
    .ref_clk (ref_clk),
    .wr_en   (push),
    .wr_addr (wr_ptr_ff[`SFC_Q_AW-1:0]),
    .wr_data (rx_word),
    .rd_en   (rd_en),
    .rd_addr (rd_ptr_ff[`SFC_Q_AW-1:0]),
    .rd_data (q_rdata)
  );

  always_comb begin
    logic flag_set;
    flag_set     = 1'b0;
    nxt_rx_state = rx_state_ff;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_rx_sh    = rx_sh_ff;
    nxt_crc      = crc_ff;
    nxt_xmodem   = xmodem_ff;
    nxt_op       = op_ff;
    nxt_job      = job_ff;
    nxt_rx_words = rx_words_ff;
    nxt_wr_ptr   = wr_ptr_ff;
    nxt_base_ptr = base_ptr_ff;
    nxt_go       = go_ff && !chain_take;
    nxt_fired    = fired_ff;
    nxt_ack_sh   = ack_sh_ff;
    nxt_ack_half = ack_half_ff;
    nxt_sdo      = sdo_ff;
    nxt_srst     = 1'b0;
    if (cs_s) begin
      nxt_rx_state = RX_CMD;
      nxt_bit_cnt  = 4'h0;
      nxt_sdo      = 1'b1;
      // crc choice only moves between commands
      nxt_xmodem   = cfg.crc_xmodem;
      nxt_crc      = cfg.crc_xmodem ? `SFC_CRC_INIT_XMODEM : `SFC_CRC_INIT_FALSE;
      if ((rx_state_ff == RX_DATA || rx_state_ff == RX_CRC) && is_fwd(op_ff)) begin
        if (job_ff.checked && !fired_ff) begin
          nxt_wr_ptr = base_ptr_ff;
        end else if (rx_state_ff == RX_DATA && !fired_ff) begin
          nxt_job.words = rx_words_ff;
          nxt_go        = rx_words_ff != 13'h0000;
          nxt_fired     = 1'b1;
        end else if (rx_state_ff == RX_DATA) begin
          nxt_job.words = rx_words_ff;
        end
      end
    end else begin
      if (rise) begin
        nxt_bit_cnt = bit_cnt_ff + 4'h1;
        nxt_rx_sh   = rx_word;
        if (rx_state_ff == RX_CMD || rx_state_ff == RX_DATA) begin
          nxt_crc = crc_bit(crc_ff, sdi_s);
        end
      end
      if (fall && rx_state_ff == RX_ACK) begin
        nxt_sdo    = ack_sh_ff[31];
        nxt_ack_sh = {ack_sh_ff[30:0], 1'b1};
      end else if (fall) begin
        nxt_sdo = 1'b1;
      end
      if (word_done) begin
        case (rx_state_ff)
          RX_CMD: begin
            nxt_op       = rx_word[15:12];
            nxt_rx_words = 13'h0000;
            nxt_base_ptr = wr_ptr_ff;
            nxt_rx_state = RX_SKIP;
            if (is_fwd(rx_word[15:12])) begin
              nxt_fired       = 1'b0;
              nxt_job.checked = is_chk(rx_word[15:12]);
              nxt_job.extra   = 7'h00;
            end
            case (rx_word[15:12])
              `SFC_OP_FWD_CHK: begin
                nxt_job.words = {4'h0, rx_word[8:0]} + 13'h0001;
                nxt_rx_state  = RX_DATA;
              end
              `SFC_OP_FWD: begin
                nxt_job.words = {1'b0, rx_word[11:0]} + 13'h0001;
                nxt_rx_state  = RX_DATA;
              end
              `SFC_OP_EXT_CHK, `SFC_OP_EXT: begin
                nxt_job.words = {8'h00, rx_word[11:7]};
                nxt_job.extra = rx_word[6:0];
                if (rx_word[11:7] == 5'h00) begin
                  nxt_rx_state = RX_CRC;
                  // nothing left to receive, unchecked may go now
                  if (rx_word[15:12] == `SFC_OP_EXT) begin
                    nxt_go    = 1'b1;
                    nxt_fired = 1'b1;
                  end
                end else begin
                  nxt_rx_state = RX_DATA;
                end
              end
              `SFC_OP_SRST: begin
                if (rx_word[11:0] == `SFC_SRST_DATA) begin
                  nxt_rx_state = RX_CRC;
                end
              end
              default: begin
                nxt_rx_state = RX_SKIP;
              end
            endcase
          end
          RX_DATA: begin
            nxt_rx_words = rx_words_ff + 13'h0001;
            if (!q_full) begin
              nxt_wr_ptr = wr_ptr_ff + 11'h001;
            end
            if (nxt_rx_words == job_ff.words) begin
              nxt_rx_state = RX_CRC;
            end
            if (!job_ff.checked && !fired_ff &&
                (lvl_hit || nxt_rx_words == job_ff.words)) begin
              nxt_go    = 1'b1;
              nxt_fired = 1'b1;
            end
          end
          RX_CRC: begin
            nxt_rx_state = RX_SKIP;
            if (crc_hit && job_ff.checked && is_fwd(op_ff)) begin
              nxt_go    = 1'b1;
              nxt_fired = 1'b1;
            end
            if (crc_hit && op_ff == `SFC_OP_SRST) begin
              nxt_srst = 1'b1;
            end
            if (crc_miss && is_fwd(op_ff) && !job_ff.checked) begin
              flag_set = 1'b1;
            end
            // refused checked data must not linger for the next job
            if (crc_miss && is_fwd(op_ff) && job_ff.checked) begin
              nxt_wr_ptr = base_ptr_ff;
            end
            // reset without ack: host must leave a word gap
            if (!cfg.ack_disable_bit &&
                (is_fwd(op_ff) || crc_hit)) begin
              nxt_rx_state = RX_ACK;
              nxt_ack_half = 1'b0;
              nxt_ack_sh   = {status_word, crc_word(xmodem_ff ?
                             `SFC_CRC_INIT_XMODEM : `SFC_CRC_INIT_FALSE, status_word)};
            end
          end
          RX_ACK: begin
            nxt_ack_half = 1'b1;
            if (ack_half_ff) begin
              nxt_rx_state = RX_SKIP;
            end
          end
          default: begin
            nxt_rx_state = rx_state_ff;
          end
        endcase
      end
    end
    // a fresh mismatch wins over a clear in the same cycle
    nxt_flag     = flag_set | (flag_ff & ~crc_flag_clr);
    nxt_fault_oe = nxt_flag & ~cfg.fault_mask;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rx_state_ff <= RX_CMD;
      bit_cnt_ff  <= 4'h0;
      rx_sh_ff    <= 16'h0000;
      crc_ff      <= `SFC_CRC_INIT_FALSE;
      xmodem_ff   <= 1'b0;
      op_ff       <= 4'h0;
      job_ff      <= '0;
      rx_words_ff <= 13'h0000;
      wr_ptr_ff   <= 11'h000;
      base_ptr_ff <= 11'h000;
      go_ff       <= 1'b0;
      fired_ff    <= 1'b0;
      ack_sh_ff   <= 32'hFFFFFFFF;
      ack_half_ff <= 1'b0;
      sdo_ff      <= 1'b1;
      flag_ff     <= 1'b0;
      fault_oe_ff <= 1'b0;
      srst_ff     <= 1'b0;
    end else begin
      rx_state_ff <= nxt_rx_state;
      bit_cnt_ff  <= nxt_bit_cnt;
      rx_sh_ff    <= nxt_rx_sh;
      crc_ff      <= nxt_crc;
      xmodem_ff   <= nxt_xmodem;
      op_ff       <= nxt_op;
      job_ff      <= nxt_job;
      rx_words_ff <= nxt_rx_words;
      wr_ptr_ff   <= nxt_wr_ptr;
      base_ptr_ff <= nxt_base_ptr;
      go_ff       <= nxt_go;
      fired_ff    <= nxt_fired;
      ack_sh_ff   <= nxt_ack_sh;
      ack_half_ff <= nxt_ack_half;
      sdo_ff      <= nxt_sdo;
      flag_ff     <= nxt_flag;
      fault_oe_ff <= nxt_fault_oe;
      srst_ff     <= nxt_srst;
    end
  end

  // chain side: bit pacing, framing, queue drain
  always_comb begin
    nxt_div      = tick ? 4'h0 : div_ff + 4'h1;
    nxt_clk      = nxt_div >= DIV_HALF;
    nxt_ch_state = ch_state_ff;
    nxt_ch_sh    = ch_sh_ff;
    nxt_ch_bit   = ch_bit_ff;
    nxt_sent     = sent_ff;
    nxt_ends     = ends_ff;
    nxt_rd_ptr   = rd_ptr_ff;
    nxt_out      = out_ff;
    case (ch_state_ff)
      CH_IDLE: begin
        if (chain_take) begin
          nxt_sent   = 13'h0000;
          nxt_ends   = {1'b0, job_ff.extra} + {7'h00, job_ff.words != 13'h0000};
          nxt_ch_sh  = {`SFC_END_BYTE, 8'h00};
          nxt_ch_bit = 4'h0;
          if (job_ff.words != 13'h0000) begin
            nxt_out      = `SFC_START_BIT;
            nxt_ch_state = CH_FETCH;
          end else begin
            nxt_out      = `SFC_CHAIN_IDLE;
            nxt_ch_state = CH_END;
          end
        end else if (tick) begin
          nxt_out = `SFC_CHAIN_IDLE;
        end
      end
      CH_FETCH: begin
        // an aborted unchecked command may shrink the count
        if (sent_ff >= job_ff.words) begin
          nxt_ch_sh    = {`SFC_END_BYTE, 8'h00};
          nxt_ch_bit   = 4'h0;
          nxt_ch_state = CH_END;
        end else if (rd_en) begin
          nxt_rd_ptr   = rd_ptr_ff + 11'h001;
          nxt_ch_state = CH_LOAD;
        end
      end
      CH_LOAD: begin
        nxt_ch_sh    = q_rdata;
        nxt_ch_bit   = 4'h0;
        nxt_ch_state = CH_WORD;
      end
      CH_WORD: begin
        if (tick) begin
          nxt_out    = ch_sh_ff[15];
          nxt_ch_sh  = {ch_sh_ff[14:0], 1'b0};
          nxt_ch_bit = ch_bit_ff + 4'h1;
          if (ch_bit_ff == 4'hF) begin
            nxt_ch_state = CH_CHECK;
          end
        end
      end
      CH_CHECK: begin
        if (tick) begin
          nxt_out  = ~out_ff;
          nxt_sent = sent_ff + 13'h0001;
          if (nxt_sent >= job_ff.words) begin
            nxt_ch_sh    = {`SFC_END_BYTE, 8'h00};
            nxt_ch_bit   = 4'h0;
            nxt_ch_state = CH_END;
          end else begin
            nxt_ch_state = CH_FETCH;
          end
        end
      end
      CH_END: begin
        if (ends_ff == 8'h00) begin
          nxt_ch_state = CH_IDLE;
        end else if (tick) begin
          nxt_out    = ch_sh_ff[15];
          nxt_ch_sh  = {ch_sh_ff[14:0], 1'b0};
          nxt_ch_bit = ch_bit_ff + 4'h1;
          if (ch_bit_ff == 4'h7) begin
            nxt_ends   = ends_ff - 8'h01;
            nxt_ch_sh  = {`SFC_END_BYTE, 8'h00};
            nxt_ch_bit = 4'h0;
          end
        end
      end
      default: begin
        nxt_ch_state = CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ch_state_ff <= CH_IDLE;
      div_ff      <= 4'h0;
      clk_ff      <= 1'b0;
      ch_sh_ff    <= 16'h0000;
      ch_bit_ff   <= 4'h0;
      sent_ff     <= 13'h0000;
      ends_ff     <= 8'h00;
      rd_ptr_ff   <= 11'h000;
      out_ff      <= `SFC_CHAIN_IDLE;
    end else begin
      ch_state_ff <= nxt_ch_state;
      div_ff      <= nxt_div;
      clk_ff      <= nxt_clk;
      ch_sh_ff    <= nxt_ch_sh;
      ch_bit_ff   <= nxt_ch_bit;
      sent_ff     <= nxt_sent;
      ends_ff     <= nxt_ends;
      rd_ptr_ff   <= nxt_rd_ptr;
      out_ff      <= nxt_out;
    end
  end

  assign spi_sdo          = sdo_ff;
  assign spi_sdo_oe       = ~cs_s;
  assign flag_spi_crc     = flag_ff;
  assign fault_out        = 1'b0;
  assign fault_oe         = fault_oe_ff;
  assign soft_reset_req   = srst_ff;
  assign chain_clk        = clk_ff;
  assign chain_serial_out = out_ff;
  assign chain_busy       = ch_state_ff != CH_IDLE;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_sdo_idle_high: assert property (
    (rx_state_ff == RX_CMD || rx_state_ff == RX_DATA) |-> spi_sdo)
    else $error("sdo not high outside answer");
  a_ack_after_fwd: assert property (
    (word_done && rx_state_ff == RX_CRC && is_fwd(op_ff) && !cfg.ack_disable_bit
     && !cs_s) |=> (rx_state_ff == RX_ACK && ack_sh_ff[31:16] == $past(status_word)))
    else $error("status answer missing");
  a_ack_disabled: assert property (
    (word_done && rx_state_ff == RX_CRC && cfg.ack_disable_bit) |=> rx_state_ff != RX_ACK)
    else $error("answer sent while disabled");
  a_checked_waits: assert property (
    ($rose(go_ff) && job_ff.checked) |-> $past(crc_hit))
    else $error("checked forward started without crc match");
  a_crc_flag_set: assert property (
    (crc_miss && is_fwd(op_ff) && !job_ff.checked) |=> flag_spi_crc ##1 flag_spi_crc || $past(crc_flag_clr))
    else $error("crc flag not set on mismatch");
  a_fault_follows: assert property (
    (flag_ff && !cfg.fault_mask && $stable(cfg.fault_mask) && !crc_flag_clr) |=> fault_oe)
    else $error("fault pin not driven");
  a_level_start: assert property (
    (push && !job_ff.checked && !fired_ff && lvl_hit) |=> (go_ff || chain_busy))
    else $error("unchecked forward did not start");
  a_push_word: assert property (
    push |=> wr_ptr_ff == $past(wr_ptr_ff) + 11'h001)
    else $error("data word not queued");
  a_checked_discard: assert property (
    (crc_miss && is_fwd(op_ff) && job_ff.checked) |=> wr_ptr_ff == $past(base_ptr_ff))
    else $error("refused checked data kept in queue");
  a_zero_words: assert property (
    (chain_take && job_ff.words == 13'h0000) |=> (ch_state_ff == CH_END && out_ff == `SFC_CHAIN_IDLE))
    else $error("start bit sent for zero words");
  a_end_count: assert property (
    (chain_take && job_ff.words != 13'h0000) |=> ends_ff == {1'b0, $past(job_ff.extra)} + 8'h01)
    else $error("end byte count wrong");

  c_unchecked_fwd: cover property ($rose(go_ff) && !job_ff.checked && op_ff == `SFC_OP_FWD);
  c_checked_fwd: cover property ($rose(go_ff) && job_ff.checked);
  c_ext_only_ends: cover property (chain_take && job_ff.words == 13'h0000 && job_ff.extra != 7'h00);
  c_ack_sent: cover property (rx_state_ff == RX_ACK && word_done && ack_half_ff);
endmodule
`default_nettype wire

// ===== logic/sfc_defs.svh
// constants for the forward command executor: opcodes, crc, queue, timing
// assumes a 200 MHz ref_clk and a host SPI link in mode 0, msb first
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH
`define SFC_Q_AW 10
`define SFC_Q_DEPTH 1024
`define SFC_CNT_W 13
`define SFC_OP_FWD_CHK 4'h2
`define SFC_OP_FWD 4'h3
`define SFC_OP_EXT_CHK 4'h4
`define SFC_OP_EXT 4'h5
`define SFC_OP_SRST 4'hE
`define SFC_SRST_DATA 12'h1E1
`define SFC_CRC_POLY 16'h1021
`define SFC_CRC_INIT_FALSE 16'hFFFF
`define SFC_CRC_INIT_XMODEM 16'h0000
`define SFC_CLK_PS 5000
`define SFC_CHAIN_BIT_PS 50000
`define SFC_CHAIN_DIV (`SFC_CHAIN_BIT_PS / `SFC_CLK_PS)
`define SFC_CHAIN_IDLE 1'b1
`define SFC_START_BIT 1'b0
`define SFC_END_BYTE 8'h00
`endif

// ===== logic/sfc_pkg.sv
// types shared by the forward command executor
// assumes sfc_defs.svh on the include path
`include "sfc_defs.svh"
package sfc_pkg;
  typedef enum logic [2:0] {
    RX_CMD, RX_DATA, RX_CRC, RX_ACK, RX_SKIP
  } sfc_rx_state_t;
  typedef enum logic [2:0] {
    CH_IDLE, CH_FETCH, CH_LOAD, CH_WORD, CH_CHECK, CH_END
  } sfc_ch_state_t;
  typedef struct packed {
    logic                 ack_disable_bit;
    logic                 crc_xmodem;
    logic                 fault_mask;
    logic [`SFC_Q_AW:0]   tx_queue_start_level;
  } sfc_cfg_t;
  typedef struct packed {
    logic                  checked;
    logic [`SFC_CNT_W-1:0] words;
    logic [6:0]            extra;
  } sfc_job_t;
endpackage

// ===== logic/sfc_queue_mem.sv
// transmit queue storage, one write and one registered read port
// assumes the caller keeps pointers and full/empty state
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.svh"
module sfc_queue_mem (
  input  wire logic                 ref_clk,
  input  wire logic                 wr_en,
  input  wire logic [`SFC_Q_AW-1:0] wr_addr,
  input  wire logic [15:0]          wr_data,
  input  wire logic                 rd_en,
  input  wire logic [`SFC_Q_AW-1:0] rd_addr,
  output logic      [15:0]          rd_data
);
  logic [15:0] mem [`SFC_Q_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// ===== tb/sfc_host_model.sv
// host spi controller model: mode 0, msb first, 64 ns sclk
// assumes the bench frames commands with sel and word calls
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b1;
  end
  // sclk stays low outside frames
  task automatic sel(input logic on);
    spi_cs_n = !on;
    if (!on)
      spi_sdi = !spi_sdi;  // released line shows no stale level
    // quarter-ns offset keeps every pin change off the ref_clk edges
    #100.25;
  endtask
  task automatic word(input logic [15:0] w, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = w[i];
      #32 spi_sclk = 1'b1;
      r[i] = spi_sdo;
      #32 spi_sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/sfc_forward_executor_tb.sv
// self-checking bench for the forward command executor
// assumes the host model on the spi pins and a 200 MHz ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.svh"
module sfc_forward_executor_tb;
  import sfc_pkg::*;
  logic        ref_clk, reset_n, crc_flag_clr, spi_sdo, spi_sdo_oe, flag_spi_crc;
  logic        fault_out, fault_oe, soft_reset_req, chain_clk, chain_serial_out, chain_busy;
  wire logic   spi_sclk, spi_cs_n, spi_sdi;
  logic        armed = 1'b0;
  logic [15:0] status_word;
  sfc_cfg_t    cfg;
  int          fails, check_count, seed, srst_seen;
  logic [15:0] r;
  logic        chain_q[$];
  sfc_host_model host (.spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo);
  sfc_forward_executor dut (.ref_clk, .reset_n, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo,
    .spi_sdo_oe, .cfg, .status_word, .crc_flag_clr, .flag_spi_crc, .fault_out, .fault_oe,
    .soft_reset_req, .chain_clk, .chain_serial_out, .chain_busy);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] crc_of(input logic [15:0] c, input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? `SFC_CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // arms on the first low bit, so idle cycles before the start tick are skipped
  // the last bit still stands after busy drops, so disarm only after checking it
  always @(posedge chain_clk) begin
    if (armed || (chain_busy && !chain_serial_out)) begin
      if (chain_q.size() == 0)
        chk("chain extra bit", 16'h0001, 16'h0000);
      else
        chk("chain bit", 16'(chain_q.pop_front()), 16'(chain_serial_out));
    end
    armed = chain_busy && (armed || !chain_serial_out);
  end
  // soft reset request lasts one cycle, so count it where it stands
  always @(posedge ref_clk) begin
    if (soft_reset_req === 1'b1)
      srst_seen++;
  end
  task automatic run(input logic [3:0] op, input int n, input int ext, input logic bad);
    logic [15:0] cw, w, crc, r0, r1, ci;
    logic        ok;
    int          nb;
    cw = (op < 4'h4) ? {op, 12'(n - 1)} : {op, 5'(n), 7'(ext)};
    ok = !bad || op[0];
    nb = (n > 0) ? 8 + 8 * ext : 8 * ext;
    @(posedge ref_clk) #1;
    status_word = 16'($random(seed));
    cfg.fault_mask = 1'($random(seed));
    ci = cfg.crc_xmodem ? `SFC_CRC_INIT_XMODEM : `SFC_CRC_INIT_FALSE;
    crc = crc_of(ci, cw);
    host.sel(1'b1);
    host.word(cw, r0);
    if (ok && n > 0) chain_q.push_back(1'b0);
    for (int k = 0; k < n; k++) begin
      w = 16'($random(seed));
      crc = crc_of(crc, w);
      host.word(w, r0);
      for (int b = 15; b >= 0; b--) if (ok) chain_q.push_back(w[b]);
      if (ok) chain_q.push_back(!w[0]);
    end
    repeat (nb) if (ok) chain_q.push_back(1'b0);
    host.word(bad ? ~crc : crc, r0);
    host.word(16'hFFFF, r0);
    host.word(16'hFFFF, r1);
    host.sel(1'b0);
    chk("ack status", cfg.ack_disable_bit ? 16'hFFFF : status_word, r0);
    chk("ack crc", cfg.ack_disable_bit ? 16'hFFFF : crc_of(ci, status_word), r1);
    chk("sdo enable", 16'h0000, 16'(spi_sdo_oe));
    chk("fault level", 16'h0000, 16'(fault_out));
    chk("crc flag", 16'(bad && op[0]), 16'(flag_spi_crc));
    chk("fault drive", 16'(bad && op[0] && !cfg.fault_mask), 16'(fault_oe));
    @(posedge ref_clk) #1 crc_flag_clr = 1'b1;
    @(posedge ref_clk) #1 crc_flag_clr = 1'b0;
    for (int t = 0; t < 20000 && (chain_busy || chain_q.size() > 0); t++) @(posedge ref_clk);
    chk("chain bits left", 16'h0000, 16'(chain_q.size()));
    chk("chain busy", 16'h0000, 16'(chain_busy));
  endtask
  initial begin
    seed = 32'h232e;
    reset_n = 1'b0;
    crc_flag_clr = 1'b0;
    status_word = 16'h0000;
    cfg = '{ack_disable_bit: 1'b0, crc_xmodem: 1'b0, fault_mask: 1'b0,
            tx_queue_start_level: 11'h7FF};
    repeat (3) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (5) @(posedge ref_clk);
    run(4'h3, 2, 0, 1'b0);
    run(4'h2, 1, 0, 1'b0);
    run(4'h2, 3, 0, 1'b1);
    run(4'h3, 1, 0, 1'b1);
    run(4'h4, 0, 3, 1'b0);
    run(4'h5, 2, 1, 1'b1);
    run(4'h4, 31, 127, 1'b0);
    @(posedge ref_clk) #1 cfg.tx_queue_start_level = 11'h002;
    run(4'h3, 3, 0, 1'b0);
    @(posedge ref_clk) #1 cfg.ack_disable_bit = 1'b1;
    run(4'h3, 1, 0, 1'b0);
    for (int b = 0; b < 2; b++) begin
      host.sel(1'b1);
      chk("sdo enable", 16'h0001, 16'(spi_sdo_oe));
      host.word(16'hE1E1, r);
      host.word(crc_of(`SFC_CRC_INIT_FALSE, 16'hE1E1) ^ 16'(b), r);
      host.word(16'hFFFF, r);
      host.sel(1'b0);
      chk("unacked sdo", 16'hFFFF, r);
      #1024;
    end
    chk("soft reset pulses", 16'h0001, 16'(srst_seen));
    @(posedge ref_clk) #1 cfg.ack_disable_bit = 1'b0;
    cfg.crc_xmodem = 1'b1;
    run(4'h2, 2, 0, 1'b0);
    run(4'h3, 1, 0, 1'b1);
    test_done();
  end
endmodule
`default_nettype wire
